// ---- cap_sense_conversion_control_bench.sv ----
/* Self-checking bench of csc_top: registers, start modes, accumulation,
   compare and auto-scan. Assumes csc_front_model as the front end. */
`timescale 1ns/10ps
module cap_sense_conversion_control_bench;
   import csc_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, slow = 1'b0;
   logic [7:0] addr = 8'h00, wd = 8'h00, rd;
   logic [3:0] tmr = 4'h0;
   logic req, ack, en, busy, done, cmpf, unc;
   logic [15:0] sd, last = 16'h0000, thr = 16'h0000;
   logic [4:0] ch, hold;
   logic [19:0] sum = 20'h00000;
   logic [1:0] acu = 2'h0;
   logic [7:0] amap [7] = '{8'h92, 8'h93, 8'h96, 8'h97, 8'h9E, 8'hA9, 8'hAA};
   logic [7:0] emask [7] = '{8'h1F, 8'h1F, 8'hFF, 8'hFF, 8'h73, 8'h00, 8'h00};
   int n_mismatch = 0, n_tests = 0, cnt = 0, nres = 0;
   always #5 clk = ~clk;
   csc_top dut_u(.clk(clk), .rst_n(rst_n), .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wd), .sfr_rdata(rd),
      .timer0_ovf(tmr[0]), .timer1_ovf(tmr[1]), .timer2_ovf(tmr[2]), .timer3_ovf(tmr[3]),
      .sample_req(req), .sample_ack(ack), .sample_data(sd), .channel_select(ch), .pins_disconnect(unc),
      .sense_enable(en), .conversion_busy_bit(busy), .conversion_done_flag(done),
      .threshold_exceeded_flag(cmpf));
   csc_front_model fe_u(.clk(clk), .rst_n(rst_n), .sample_req(req), .slow(slow), .sample_ack(ack),
      .sample_data(sd));
   // ---------------------------------------------------------------
   // expectation helpers
   // ---------------------------------------------------------------
   function automatic int nsamp(logic [1:0] a);
      return (a == 2'h0) ? 1 : (2 << a);
   endfunction
   // sum of acked samples divided by the sample count
   always @(posedge clk) begin
      if (rst_n && ack === 1'b1) begin
         sum = sum + 20'(sd);
         cnt++;
         if (cnt == nsamp(acu)) begin
            last = 16'(sum / 20'(nsamp(acu)));
            sum = 20'h00000;
            cnt = 0;
            nres++;
         end
      end
   end
   task automatic give_verdict();
      $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(logic [15:0] g, logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr_reg(logic [7:0] a, logic [7:0] d);
      @(negedge clk);
      addr = a;
      wd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rd_chk(logic [7:0] a, logic [7:0] e);
      @(negedge clk);
      addr = a;
      #1;
      chk(16'(rd), 16'(e));
   endtask
   task automatic wait_done();
      int i;
      for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk);
      if (done !== 1'b1) begin
         n_mismatch++;
         $display("unexpected at %0t: no result", $time);
         give_verdict();
      end
   endtask
   task automatic conv(logic [2:0] m);
      int r0;
      r0 = nres;
      wr_reg(8'h96, thr[7:0]);
      wr_reg(8'h97, thr[15:8]);
      wr_reg(8'h9E, {1'b0, m, 2'h0, acu});
      wr_reg(8'h9A, 8'h88);
      if (m == 3'h0) wr_reg(8'h9A, 8'h98);
      else begin
         @(negedge clk);
         tmr[(m == 3'h2) ? 2 : (m == 3'h3) ? 1 : (m == 3'h4) ? 3 : 0] = 1'b1;
         @(negedge clk);
         tmr = 4'h0;
      end
      @(negedge clk);
      tmr = 4'hF;
      @(negedge clk);
      tmr = 4'h0;
      wait_done();
      chk(16'(nres - r0), 16'h0001);
      rd_chk(8'hAA, last[15:8]);
      rd_chk(8'hA9, last[7:0]);
      chk(16'(cmpf), 16'(last > thr));
      chk(16'({en, busy, done}), 16'h0005);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      int k;
      void'($urandom(69411));
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      for (k = 0; k < 7; k++) rd_chk(amap[k], 8'h00);
      for (k = 0; k < 7; k++) wr_reg(amap[k], 8'hFF);
      wr_reg(8'h91, 8'hFF);
      for (k = 0; k < 7; k++) rd_chk(amap[k], emask[k]);
      rd_chk(8'h91, 8'h00);
      for (k = 0; k < 24; k++) begin
         acu = 2'(k % 4);
         slow = 1'($urandom);
         thr = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($urandom);
         conv(3'(k % 5));
      end
      wr_reg(8'h9E, 8'h50);
      wr_reg(8'h9A, 8'h98);
      @(negedge clk);
      tmr = 4'hF;
      @(negedge clk);
      tmr = 4'h0;
      chk(16'(busy), 16'h0000);
      acu = 2'h1;
      slow = 1'b0;
      wr_reg(8'h9E, 8'h61);
      wr_reg(8'h9A, 8'h90);
      for (k = 0; k < 3; k++) begin
         wait_done();
         rd_chk(8'hAA, last[15:8]);
         wr_reg(8'h9A, 8'h80);
         chk(16'(busy), 16'h0001);
      end
      wr_reg(8'h9E, 8'h01);
      wait_done();
      repeat (3) @(negedge clk);
      chk(16'(busy), 16'h0000);
      wr_reg(8'h97, 8'hFF);
      wr_reg(8'h96, 8'hFF);
      wr_reg(8'h92, 8'h03);
      wr_reg(8'h93, 8'h05);
      wr_reg(8'h9C, 8'h03);
      chk(16'({unc, ch}), 16'h0003);
      wr_reg(8'h9E, 8'h71);
      wr_reg(8'h9A, 8'h80);
      wr_reg(8'h9A, 8'h90);
      for (k = 0; k < 4; k++) begin
         wait_done();
         chk(16'(ch), 16'(3 + (k + 1) % 3));
         wr_reg(8'h9A, 8'h80);
      end
      hold = ch;
      wr_reg(8'h97, 8'h00);
      wr_reg(8'h96, 8'h00);
      wr_reg(8'h9A, 8'h88);
      wait_done();
      repeat (20) @(negedge clk);
      chk(16'({busy, cmpf, ch}), 16'({1'b0, last != 16'h0000, hold}));
      wr_reg(8'h92, 8'h0A);
      chk(16'(ch), 16'h000A);
      wr_reg(8'h9C, 8'h85);
      chk(16'({unc, ch}), 16'h0025);
      give_verdict();
   end
endmodule

// ---- csc_accum.sv ----
/*
 * Sample accumulator: requests samples from the analog front end, sums
 * them in 20 bits and divides by the sample count.
 * Assumes the front end answers each request with one ack pulse later.
 */
`timescale 1ns/10ps
module csc_accum
   import csc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [1:0] acu,
   input wire logic sample_ack,
   input wire logic [15:0] sample_data,
   output logic sample_req,
   output logic done,
   output logic [15:0] quotient
);

   logic active;
   logic [4:0] count;
   logic [19:0] sum;
   logic next_active;
   logic [4:0] next_count;
   logic [19:0] next_sum;
   logic next_done;
   logic [15:0] next_quotient;
   logic [19:0] sum_add;
   logic [19:0] sum_div;
   logic [4:0] count_inc;
   logic last;

   assign sum_add = sum + {4'h0, sample_data};
   assign sum_div = sum_add >> csc_acc_shift(acu);
   assign count_inc = count + 5'h01;
   assign last = (count_inc == (5'h01 << csc_acc_shift(acu)));
   assign sample_req = start | (active & sample_ack & ~last);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_active = active;
      next_count = count;
      next_sum = sum;
      next_done = 1'b0;
      next_quotient = quotient;
      if (start) begin
         next_active = 1'b1;
         next_count = CSC_COUNT_RESET;
         next_sum = CSC_SUM_RESET;
      end else if (active && sample_ack) begin
         if (last) begin
            next_active = 1'b0;
            next_done = 1'b1;
            next_quotient = sum_div[15:0];
         end else begin
            next_sum = sum_add;
            next_count = count_inc;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active <= 1'b0;
         count <= CSC_COUNT_RESET;
         sum <= CSC_SUM_RESET;
         done <= 1'b0;
         quotient <= CSC_WORD_RESET;
      end else begin
         active <= next_active;
         count <= next_count;
         sum <= next_sum;
         done <= next_done;
         quotient <= next_quotient;
      end
   end

endmodule

// ---- csc_front_model.sv ----
/* Analog front end model: answers each sample request with one ack.
   Assumes requests are one-cycle pulses synchronous to clk. */
`timescale 1ns/10ps
module csc_front_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sample_req,
   input wire logic slow,
   output logic sample_ack,
   output logic [15:0] sample_data
);
   int wait_n;
   // data toggles outside an ack so a stale value is never trusted
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_ack <= 1'b0;
         sample_data <= 16'h0000;
         wait_n = 0;
      end else begin
         if (wait_n == 1) begin
            sample_ack <= 1'b1;
            sample_data <= 16'($urandom);
         end else begin
            sample_ack <= 1'b0;
            sample_data <= ~sample_data;
         end
         if (wait_n > 0) wait_n--;
         if (sample_req === 1'b1) wait_n = slow ? 1 + $urandom_range(3) : 1;
      end
   end
endmodule

// ---- csc_pkg.sv ----
/*
 * Constants, register map and field layout of the capacitive sense
 * conversion control block.
 * Assumes an 8-bit special-function-register space addressed by 8 bits.
 */
package csc_pkg;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] CSC_ADDR_SCAN_FIRST = 8'h92;
   localparam logic [7:0] CSC_ADDR_SCAN_LAST = 8'h93;
   localparam logic [7:0] CSC_ADDR_THR_LOW = 8'h96;
   localparam logic [7:0] CSC_ADDR_THR_HIGH = 8'h97;
   localparam logic [7:0] CSC_ADDR_CONTROL = 8'h9A;
   localparam logic [7:0] CSC_ADDR_CHAN_SEL = 8'h9C;
   localparam logic [7:0] CSC_ADDR_CONFIG = 8'h9E;
   localparam logic [7:0] CSC_ADDR_RES_LOW = 8'hA9;
   localparam logic [7:0] CSC_ADDR_RES_HIGH = 8'hAA;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CSC_CFG_MODE_LSB = 4;
   localparam int CSC_CFG_ACU_LSB = 0;
   localparam int CSC_CTL_ENABLE = 7;
   localparam int CSC_CTL_DONE = 5;
   localparam int CSC_CTL_BUSY = 4;
   localparam int CSC_CTL_CMPEN = 3;
   localparam int CSC_CTL_CMPF = 0;
   localparam int CSC_MUX_UNCONN = 7;

   // ---------------------------------------------------------------
   // reset values and widths
   // ---------------------------------------------------------------
   localparam logic [4:0] CSC_CHAN_RESET = 5'h00;
   localparam logic [15:0] CSC_WORD_RESET = 16'h0000;
   localparam logic [7:0] CSC_READ_ZERO = 8'h00;
   localparam logic [19:0] CSC_SUM_RESET = 20'h00000;
   localparam logic [4:0] CSC_COUNT_RESET = 5'h00;

   // ---------------------------------------------------------------
   // start-of-conversion modes
   // ---------------------------------------------------------------
   localparam logic [2:0] CSC_MODE_SOFT = 3'h0;
   localparam logic [2:0] CSC_MODE_TMR0 = 3'h1;
   localparam logic [2:0] CSC_MODE_TMR2 = 3'h2;
   localparam logic [2:0] CSC_MODE_TMR1 = 3'h3;
   localparam logic [2:0] CSC_MODE_TMR3 = 3'h4;
   localparam logic [2:0] CSC_MODE_RESV = 3'h5;
   localparam logic [2:0] CSC_MODE_CONT = 3'h6;
   localparam logic [2:0] CSC_MODE_SCAN = 3'h7;

   typedef enum logic [0:0] {CSC_ST_IDLE, CSC_ST_CONV} csc_state_t;

   // accumulation code to divide shift: 1, 4, 8, 16 samples
   function automatic logic [2:0] csc_acc_shift(input logic [1:0] acu);
      case (acu)
         2'h0: csc_acc_shift = 3'h0;
         2'h1: csc_acc_shift = 3'h2;
         2'h2: csc_acc_shift = 3'h3;
         default: csc_acc_shift = 3'h4;
      endcase
   endfunction

endpackage

// ---- csc_scan.sv ----
/*
 * Threshold compare and auto-scan channel step, purely combinational.
 * Assumes first and last channel values come from registers.
 */
`timescale 1ns/10ps
module csc_scan
   import csc_pkg::*;
(
   input wire logic [15:0] result,
   input wire logic [15:0] threshold,
   input wire logic [4:0] current,
   input wire logic [4:0] first,
   input wire logic [4:0] last,
   output logic above,
   output logic [4:0] next_channel
);

   assign above = (result > threshold);

   assign next_channel = (current == last) ? first : (current + 5'h01);

endmodule

// ---- csc_top.sv ----
/*
 * Capacitive sense conversion control: register file on the special
 * function register bus, start-of-conversion selection, accumulation,
 * threshold compare and auto-scan of the channel multiplexer.
 * Assumes bus strobes, timer overflows and front-end acks are one-cycle
 * pulses synchronous to clk.
 */
//
// Summary of operation
// - mode 000 starts on busy write
// - modes 001-100 start on timer overflow
// - mode 110 restarts continuously after busy write
// - mode 111 auto-scans continuously after busy write
// - accumulation field picks 1/4/8/16 samples
// - last 16-bit result readable as two bytes
// - scan first register holds start channel
// - scan first write loads channel during scan
// - scan last register holds end channel
// - result compared against 16-bit threshold
// - channel select written by software or scan
// - scan register upper bits read zero
// - 20-bit sum divided to 16-bit result
// - scan advances at or below threshold, else stops
// - done flag set by hardware, software clears
// - threshold flag sticky until software clears
`timescale 1ns/10ps
module csc_top
   import csc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic timer0_ovf,
   input wire logic timer1_ovf,
   input wire logic timer2_ovf,
   input wire logic timer3_ovf,
   output logic sample_req,
   input wire logic sample_ack,
   input wire logic [15:0] sample_data,
   output logic [4:0] channel_select,
   output logic pins_disconnect,
   output logic sense_enable,
   output logic conversion_busy_bit,
   output logic conversion_done_flag,
   output logic threshold_exceeded_flag
);

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [2:0] start_mode_field;
   logic [1:0] accumulation_field;
   logic [4:0] scan_first_channel;
   logic [4:0] scan_last_channel;
   logic [7:0] threshold_low_byte;
   logic [7:0] threshold_high_byte;
   logic [7:0] result_low_byte;
   logic [7:0] result_high_byte;
   logic compare_enable;
   csc_state_t state;

   logic [2:0] next_start_mode_field;
   logic [1:0] next_accumulation_field;
   logic [4:0] next_scan_first_channel;
   logic [4:0] next_scan_last_channel;
   logic [7:0] next_threshold_low_byte;
   logic [7:0] next_threshold_high_byte;
   logic [7:0] next_result_low_byte;
   logic [7:0] next_result_high_byte;
   logic next_compare_enable;
   logic next_sense_enable;
   logic next_done_flag;
   logic next_cmp_flag;
   logic [4:0] next_channel_select;
   logic next_pins_disconnect;
   csc_state_t next_state;

   // ---------------------------------------------------------------
   // decode and datapath
   // ---------------------------------------------------------------
   logic wr_cfg;
   logic wr_ctl;
   logic wr_mux;
   logic wr_first;
   logic busy_write;
   logic scan_mode;
   logic cont_mode;
   logic timer_hit;
   logic trigger;
   logic acc_start;
   logic acc_done;
   logic [15:0] acc_q;
   logic above;
   logic [4:0] step_channel;
   logic restart;

   assign wr_cfg = sfr_wr & (sfr_addr == CSC_ADDR_CONFIG);
   assign wr_ctl = sfr_wr & (sfr_addr == CSC_ADDR_CONTROL);
   assign wr_mux = sfr_wr & (sfr_addr == CSC_ADDR_CHAN_SEL);
   assign wr_first = sfr_wr & (sfr_addr == CSC_ADDR_SCAN_FIRST);
   assign busy_write = wr_ctl & sfr_wdata[CSC_CTL_BUSY];
   assign scan_mode = (start_mode_field == CSC_MODE_SCAN);
   assign cont_mode = (start_mode_field == CSC_MODE_CONT) | scan_mode;

   always_comb begin
      case (start_mode_field)
         CSC_MODE_TMR0: timer_hit = timer0_ovf;
         CSC_MODE_TMR2: timer_hit = timer2_ovf;
         CSC_MODE_TMR1: timer_hit = timer1_ovf;
         CSC_MODE_TMR3: timer_hit = timer3_ovf;
         default: timer_hit = 1'b0;
      endcase
   end

   assign trigger = timer_hit | (busy_write & ((start_mode_field == CSC_MODE_SOFT) | cont_mode));

   assign restart = acc_done & cont_mode & sense_enable & ~(scan_mode & above);

   assign acc_start = sense_enable & ((state == CSC_ST_IDLE) ? trigger : restart);

   assign conversion_busy_bit = (state == CSC_ST_CONV);

   csc_accum u_accum (
      .clk(clk),
      .rst_n(rst_n),
      .start(acc_start),
      .acu(accumulation_field),
      .sample_ack(sample_ack),
      .sample_data(sample_data),
      .sample_req(sample_req),
      .done(acc_done),
      .quotient(acc_q)
   );

   csc_scan u_scan (
      .result(acc_q),
      .threshold({threshold_high_byte, threshold_low_byte}),
      .current(channel_select),
      .first(scan_first_channel),
      .last(scan_last_channel),
      .above(above),
      .next_channel(step_channel)
   );

   // ---------------------------------------------------------------
   // next values
   // ---------------------------------------------------------------
   always_comb begin
      next_start_mode_field = start_mode_field;
      next_accumulation_field = accumulation_field;
      next_scan_first_channel = scan_first_channel;
      next_scan_last_channel = scan_last_channel;
      next_threshold_low_byte = threshold_low_byte;
      next_threshold_high_byte = threshold_high_byte;
      next_result_low_byte = result_low_byte;
      next_result_high_byte = result_high_byte;
      next_compare_enable = compare_enable;
      next_sense_enable = sense_enable;
      next_done_flag = conversion_done_flag;
      next_cmp_flag = threshold_exceeded_flag;
      next_channel_select = channel_select;
      next_pins_disconnect = pins_disconnect;
      next_state = state;

      if (wr_cfg) begin
         next_start_mode_field = sfr_wdata[CSC_CFG_MODE_LSB +: 3];
         next_accumulation_field = sfr_wdata[CSC_CFG_ACU_LSB +: 2];
      end
      // scan start channel, low five bits only
      if (wr_first) begin
         next_scan_first_channel = sfr_wdata[4:0];
      end
      if (sfr_wr && sfr_addr == CSC_ADDR_SCAN_LAST) begin
         next_scan_last_channel = sfr_wdata[4:0];
      end
      if (sfr_wr && sfr_addr == CSC_ADDR_THR_LOW) begin
         next_threshold_low_byte = sfr_wdata;
      end
      if (sfr_wr && sfr_addr == CSC_ADDR_THR_HIGH) begin
         next_threshold_high_byte = sfr_wdata;
      end
      if (wr_ctl) begin
         next_sense_enable = sfr_wdata[CSC_CTL_ENABLE];
         next_compare_enable = sfr_wdata[CSC_CTL_CMPEN];
         next_done_flag = sfr_wdata[CSC_CTL_DONE];
         next_cmp_flag = threshold_exceeded_flag & sfr_wdata[CSC_CTL_CMPF];
      end
      if (wr_mux) begin
         next_pins_disconnect = sfr_wdata[CSC_MUX_UNCONN];
      end

      // software write wins over scan step
      if (wr_mux) begin
         next_channel_select = sfr_wdata[4:0];
      end else if (wr_first && scan_mode) begin
         next_channel_select = sfr_wdata[4:0];
      end else if (acc_done && scan_mode && !above) begin
         next_channel_select = step_channel;
      end

      if (acc_done) begin
         next_result_high_byte = acc_q[15:8];
         next_result_low_byte = acc_q[7:0];
         next_done_flag = 1'b1;
         if (compare_enable && above) begin
            next_cmp_flag = 1'b1;
         end
      end

      case (state)
         CSC_ST_IDLE: begin
            if (acc_start) begin
               next_state = CSC_ST_CONV;
            end
         end
         CSC_ST_CONV: begin
            if (acc_done && !restart) begin
               next_state = CSC_ST_IDLE;
            end
         end
         default: next_state = CSC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_mode_field <= CSC_MODE_SOFT;
         accumulation_field <= 2'h0;
         scan_first_channel <= CSC_CHAN_RESET;
         scan_last_channel <= CSC_CHAN_RESET;
         threshold_low_byte <= CSC_READ_ZERO;
         threshold_high_byte <= CSC_READ_ZERO;
         result_low_byte <= CSC_READ_ZERO;
         result_high_byte <= CSC_READ_ZERO;
         compare_enable <= 1'b0;
         sense_enable <= 1'b0;
         conversion_done_flag <= 1'b0;
         threshold_exceeded_flag <= 1'b0;
         channel_select <= CSC_CHAN_RESET;
         pins_disconnect <= 1'b0;
         state <= CSC_ST_IDLE;
      end else begin
         start_mode_field <= next_start_mode_field;
         accumulation_field <= next_accumulation_field;
         scan_first_channel <= next_scan_first_channel;
         scan_last_channel <= next_scan_last_channel;
         threshold_low_byte <= next_threshold_low_byte;
         threshold_high_byte <= next_threshold_high_byte;
         result_low_byte <= next_result_low_byte;
         result_high_byte <= next_result_high_byte;
         compare_enable <= next_compare_enable;
         sense_enable <= next_sense_enable;
         conversion_done_flag <= next_done_flag;
         threshold_exceeded_flag <= next_cmp_flag;
         channel_select <= next_channel_select;
         pins_disconnect <= next_pins_disconnect;
         state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb begin
      sfr_rdata = CSC_READ_ZERO;
      case (sfr_addr)
         CSC_ADDR_CONFIG: begin
            sfr_rdata[CSC_CFG_MODE_LSB +: 3] = start_mode_field;
            sfr_rdata[CSC_CFG_ACU_LSB +: 2] = accumulation_field;
         end
         CSC_ADDR_CONTROL: begin
            sfr_rdata[CSC_CTL_ENABLE] = sense_enable;
            sfr_rdata[CSC_CTL_DONE] = conversion_done_flag;
            sfr_rdata[CSC_CTL_BUSY] = conversion_busy_bit;
            sfr_rdata[CSC_CTL_CMPEN] = compare_enable;
            sfr_rdata[CSC_CTL_CMPF] = threshold_exceeded_flag;
         end
         CSC_ADDR_CHAN_SEL: begin
            sfr_rdata[CSC_MUX_UNCONN] = pins_disconnect;
            sfr_rdata[4:0] = channel_select;
         end
         CSC_ADDR_SCAN_FIRST: sfr_rdata[4:0] = scan_first_channel;
         CSC_ADDR_SCAN_LAST: sfr_rdata[4:0] = scan_last_channel;
         CSC_ADDR_THR_LOW: sfr_rdata = threshold_low_byte;
         CSC_ADDR_THR_HIGH: sfr_rdata = threshold_high_byte;
         CSC_ADDR_RES_LOW: sfr_rdata = result_low_byte;
         CSC_ADDR_RES_HIGH: sfr_rdata = result_high_byte;
         default: sfr_rdata = CSC_READ_ZERO;
      endcase
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_soft_start: assert property (@(posedge clk) disable iff (!rst_n)
      (busy_write && start_mode_field == CSC_MODE_SOFT && sense_enable && state == CSC_ST_IDLE)
      |=> conversion_busy_bit)
      else $error("software start did not raise busy");

   a_timer_start: assert property (@(posedge clk) disable iff (!rst_n)
      (start_mode_field == CSC_MODE_TMR0 && timer0_ovf && sense_enable && state == CSC_ST_IDLE)
      |-> sample_req ##1 conversion_busy_bit)
      else $error("timer 0 overflow did not start");

   a_cont_restart: assert property (@(posedge clk) disable iff (!rst_n)
      (acc_done && start_mode_field == CSC_MODE_CONT && sense_enable) |-> sample_req ##1 conversion_busy_bit)
      else $error("continuous mode did not restart");

   a_scan_step: assert property (@(posedge clk) disable iff (!rst_n)
      (acc_done && scan_mode && !above && !wr_mux && !wr_first)
      |=> channel_select == (($past(channel_select) == $past(scan_last_channel)) ? $past(scan_first_channel)
                             : $past(channel_select) + 5'h01))
      else $error("auto-scan channel step wrong");

   a_first_mirror: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_first && scan_mode && !wr_mux) |=> channel_select == $past(sfr_wdata[4:0]))
      else $error("scan start write not mirrored");

   a_result_load: assert property (@(posedge clk) disable iff (!rst_n)
      acc_done |=> {result_high_byte, result_low_byte} == $past(acc_q))
      else $error("result bytes not loaded");

   a_done_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      (conversion_done_flag && !wr_ctl) |=> conversion_done_flag)
      else $error("done flag cleared without software");

   a_cmp_set: assert property (@(posedge clk) disable iff (!rst_n)
      (acc_done && compare_enable && acc_q > {threshold_high_byte, threshold_low_byte}) |=> threshold_exceeded_flag)
      else $error("threshold flag not set");

   a_reserved_idle: assert property (@(posedge clk) disable iff (!rst_n)
      (start_mode_field == CSC_MODE_RESV && state == CSC_ST_IDLE) |-> !sample_req)
      else $error("reserved mode started a conversion");

   a_ignore_busy: assert property (@(posedge clk) disable iff (!rst_n)
      (conversion_busy_bit && !acc_done && !sample_ack) |-> !sample_req)
      else $error("trigger accepted during conversion");

endmodule
